// ===== dih_regs.sv
// Identity and configuration-memory health register group.
// Assumes the serial protocol engine presents a one-cycle 16-bit read/write
// strobe port on clk and handles memory map selection upstream.
// What this block does
// - Upper identifier byte in bits 7:0; bits 15:8 read zero, read-only.
// - Die Y wafer position in bits 14:8; bit 15 reads zero.
// - Die X wafer position in bits 6:0; bit 7 reads zero.
// - Three memory zones: green trace, yellow identifier, red config; per-zone status.
// - Memory words carry code correcting single and detecting double errors.
// - Configuration memory has no user write path.
// - Health bit 15 set on corrected red-zone single error.
// - Health bit 14 set on uncorrectable red-zone error.
// - Health bit 13 set on corrected yellow-zone single error.
// - Health bit 12 set on uncorrectable yellow-zone error.
// - Health bit 11 set on corrected green-zone single error.
// - Health bit 10 set on uncorrectable green-zone error.
// - Health bits 9:0 reserved, read-only, no defined value.
// - Device can drive a 25 MHz clock onto its clock output pin.
// - Lower identifier register holds identifier bits 15:0.
// - Disabled clock output drives constant low.
`timescale 1ns/1ps
`include "dih_consts.svh"
module dih_regs #(
  // Factory image: word0 green, word1 yellow lower id, word2 yellow upper id,
  // word3 red; each word is 16 data bits plus 6 check bits. Arbitrary value.
  parameter logic [4*22-1:0] NVM_IMAGE   = {4{22'h000000}},
  parameter logic [9:0]      MFG_RESVD   = 10'h000
) (
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          reg_rd,
  input  wire logic          reg_wr,
  input  wire logic [15:0]   reg_addr,
  input  wire logic [15:0]   reg_wdata,
  input  wire logic          clk_out_en,
  output logic      [15:0]   reg_rdata,
  output logic               reg_ack,
  output logic               reg_err,
  output logic               clock_output_pin,
  output logic               load_done
);
  // ****************************************
  // Hamming SEC-DED decode
  // ****************************************
  // Check bits 4:0 are Hamming over 16 data bits, bit 5 is overall parity.
  function automatic logic [4:0] dih_syn(input logic [15:0] d, input logic [4:0] c);
    logic [4:0] s;
    logic [4:0] pos;
    s = c;
    for (int i = 0; i < 16; i++) begin
      pos = dih_dpos(i);
      if (d[i]) s = s ^ pos;
    end
    return s;
  endfunction : dih_syn
  // Codeword position (1..21, non power of two) of data bit i
  function automatic logic [4:0] dih_dpos(input int i);
    logic [4:0] p;
    int         n;
    p = 5'h00;
    n = -1;
    for (int k = 1; k < 22; k++) begin
      if ((k & (k - 1)) != 0) begin
        n = n + 1;
        if (n == i) p = 5'(k);
      end
    end
    return p;
  endfunction : dih_dpos

  // ****************************************
  // Load sequencer
  // ****************************************
  dih_pkg::dih_load_e ld_state_ff, nxt_ld_state;
  logic [1:0]  ld_addr_ff, nxt_ld_addr;
  logic        ld_valid_ff;
  logic [1:0]  ld_word_ff;
  logic [21:0] rom_rdata;

  dih_nvm_rom #(
    .DEPTH (`DIH_NVM_WORDS),
    .IMAGE (NVM_IMAGE)
  ) u_rom (
    .clk   (clk),
    .addr  (ld_addr_ff),
    .rdata (rom_rdata)
  );

  // Read every word once after reset, then stop
  always_comb begin
    nxt_ld_state = ld_state_ff;
    nxt_ld_addr  = ld_addr_ff;
    case (ld_state_ff)
      dih_pkg::DIH_LD_IDLE: begin
        nxt_ld_state = dih_pkg::DIH_LD_READ;
      end
      dih_pkg::DIH_LD_READ: begin
        nxt_ld_addr = ld_addr_ff + 2'h1;
        if (ld_addr_ff == 2'(`DIH_NVM_WORDS - 1)) nxt_ld_state = dih_pkg::DIH_LD_DONE;
      end
      dih_pkg::DIH_LD_DONE: begin
        nxt_ld_state = dih_pkg::DIH_LD_DONE;
      end
      default: begin
        nxt_ld_state = dih_pkg::DIH_LD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ld_state_ff <= dih_pkg::DIH_LD_IDLE;
      ld_addr_ff  <= 2'h0;
      ld_valid_ff <= 1'b0;
      ld_word_ff  <= 2'h0;
    end else begin
      ld_state_ff <= nxt_ld_state;
      ld_addr_ff  <= nxt_ld_addr;
      ld_valid_ff <= (ld_state_ff == dih_pkg::DIH_LD_READ); // ROM data one cycle later
      ld_word_ff  <= ld_addr_ff;
    end
  end

  // ****************************************
  // Error classification of the word in flight
  // ****************************************
  wire logic [15:0] w_data   = rom_rdata[15:0];
  wire logic [4:0]  w_syn    = dih_syn(rom_rdata[15:0], rom_rdata[20:16]);
  wire logic        w_par    = ^rom_rdata;
  wire logic        w_single = (w_par == 1'b1);
  wire logic        w_double = (w_par == 1'b0) && (w_syn != 5'h00);
  logic [15:0]      w_fixed;
  // Flip the data bit the syndrome points at
  always_comb begin
    w_fixed = w_data;
    for (int i = 0; i < 16; i++) begin
      if (w_single && (w_syn == dih_dpos(i))) w_fixed[i] = ~w_data[i];
    end
  end
  // Zone of the word in flight
  wire dih_pkg::dih_zone_e w_zone =
    (ld_word_ff == 2'h0) ? dih_pkg::DIH_ZONE_GREEN :
    (ld_word_ff == 2'h3) ? dih_pkg::DIH_ZONE_RED : dih_pkg::DIH_ZONE_YELLOW;

  // ****************************************
  // Captured identity and health
  // ****************************************
  logic [15:0] id_lower_ff;
  logic [7:0]  id_upper_ff;
  logic [15:0] wafer_ff;
  logic [5:0]  health_ff;   // bits 15:10
  logic [5:0]  nxt_health;
  // Health bits only ever set during load; no read clears them
  always_comb begin
    nxt_health = health_ff;
    if (ld_valid_ff) begin
      case (w_zone)
        dih_pkg::DIH_ZONE_RED: begin
          nxt_health[5] = health_ff[5] | w_single;
          nxt_health[4] = health_ff[4] | w_double;
        end
        dih_pkg::DIH_ZONE_YELLOW: begin
          nxt_health[3] = health_ff[3] | w_single;
          nxt_health[2] = health_ff[2] | w_double;
        end
        dih_pkg::DIH_ZONE_GREEN: begin
          nxt_health[1] = health_ff[1] | w_single;
          nxt_health[0] = health_ff[0] | w_double;
        end
        default: begin
          nxt_health = health_ff;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      health_ff   <= `DIH_HEALTH_RST;
      id_lower_ff <= 16'h0000;
      id_upper_ff <= 8'h00;
      wafer_ff    <= 16'h0000;
    end else begin
      health_ff <= nxt_health;
      if (ld_valid_ff && ld_word_ff == 2'h0) wafer_ff    <= w_fixed;        // Green trace data
      if (ld_valid_ff && ld_word_ff == 2'h1) id_lower_ff <= w_fixed;
      if (ld_valid_ff && ld_word_ff == 2'h2) id_upper_ff <= w_fixed[7:0];
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  // Writes are accepted and ignored: the memory has no user write path
  wire logic hit_lower  = (reg_addr == `DIH_OFS_ID_LOWER);
  wire logic hit_upper  = (reg_addr == `DIH_OFS_ID_UPPER);
  wire logic hit_wafer  = (reg_addr == `DIH_OFS_WAFER_POS);
  wire logic hit_health = (reg_addr == `DIH_OFS_HEALTH);
  wire logic hit_any    = hit_lower | hit_upper | hit_wafer | hit_health;
  wire logic [15:0] rd_upper  = {8'h00, id_upper_ff};
  wire logic [15:0] rd_wafer  = {1'b0, wafer_ff[14:8], 1'b0, wafer_ff[6:0]};
  wire logic [15:0] rd_health = {health_ff, MFG_RESVD};
  wire logic [15:0] rd_mux    = hit_lower  ? id_lower_ff :
                                hit_upper  ? rd_upper :
                                hit_wafer  ? rd_wafer :
                                hit_health ? rd_health : 16'h0000;
  wire logic unused_wdata = ^reg_wdata;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
      reg_ack   <= 1'b0;
      reg_err   <= 1'b0;
      load_done <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
      reg_ack   <= reg_rd | reg_wr;
      reg_err   <= (reg_rd | reg_wr) & ~hit_any;
      load_done <= (ld_state_ff == dih_pkg::DIH_LD_DONE) & ~ld_valid_ff;
    end
  end

  // ****************************************
  // Clock output
  // ****************************************
  // clk is the 25 MHz-derived reference here; halving it keeps output glitch free
  logic clkdiv_ff;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clkdiv_ff        <= 1'b0;
      clock_output_pin <= 1'b0;
    end else begin
      clkdiv_ff        <= ~clkdiv_ff;
      clock_output_pin <= clk_out_en ? ~clkdiv_ff : 1'b0;
    end
  end
endmodule : dih_regs

// ===== dih_consts.svh
// Constants of the identity and configuration-memory health register group.
// Assumes a 16-bit register port driven by the serial protocol engine.
`ifndef DIH_CONSTS_SVH
`define DIH_CONSTS_SVH
// ****************************************
// Register offsets (selector twelve)
// ****************************************
`define DIH_OFS_ID_LOWER      16'h1002
`define DIH_OFS_ID_UPPER      16'h1003
`define DIH_OFS_WAFER_POS     16'h1004
`define DIH_OFS_HEALTH        16'h1005
// ****************************************
// Field positions
// ****************************************
`define DIH_WAFER_Y_LSB       8
`define DIH_WAFER_X_LSB       0
`define DIH_HB_RED_SB         15
`define DIH_HB_RED_DB         14
`define DIH_HB_YEL_SB         13
`define DIH_HB_YEL_DB         12
`define DIH_HB_GRN_SB         11
`define DIH_HB_GRN_DB         10
// ****************************************
// Reset values and timing
// ****************************************
`define DIH_HEALTH_RST        6'h00
`define DIH_CLK_OUT_EN_RST    1'b1
`define DIH_NVM_WORDS         4
`endif

// ===== dih_pkg.sv
// Types of the identity and health register group.
// Assumes dih_consts.svh supplies the numeric constants.
package dih_pkg;
  typedef enum logic [1:0] {
    DIH_ZONE_GREEN  = 2'h0,
    DIH_ZONE_YELLOW = 2'h1,
    DIH_ZONE_RED    = 2'h3
  } dih_zone_e;
  typedef enum logic [1:0] {
    DIH_LD_IDLE = 2'h0,
    DIH_LD_READ = 2'h1,
    DIH_LD_DONE = 2'h3
  } dih_load_e;
endpackage : dih_pkg

// ===== dih_nvm_rom.sv
// Read-only factory configuration memory with registered read data.
// Assumes contents are fixed at build time; no write port exists.
`timescale 1ns/1ps
module dih_nvm_rom #(
  parameter int                 DEPTH = 4,
  parameter logic [4*22-1:0]    IMAGE = {4{22'h000000}}
) (
  input  wire logic             clk,
  input  wire logic [1:0]       addr,
  output logic      [21:0]      rdata
);
  // Image layout and two-bit address serve exactly four words
  if (DEPTH != 4) begin : g_bad_depth
    $error("dih_nvm_rom supports DEPTH 4 only");
  end
  // Registered read; no write path by construction
  always_ff @(posedge clk) begin
    rdata <= IMAGE[addr*22 +: 22];
  end
endmodule : dih_nvm_rom

// ===== dih_regs_sva.sv
// Checker of the identity and health register port.
// Assumes it is bound onto dih_regs and sees its ports only.
`timescale 1ns/1ps
`include "dih_consts.svh"
module dih_regs_sva (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        reg_rd,
  input wire logic        reg_wr,
  input wire logic [15:0] reg_addr,
  input wire logic        clk_out_en,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_ack,
  input wire logic        reg_err,
  input wire logic        clock_output_pin,
  input wire logic        load_done
);
  // ****************
  // Request decode
  // ****************
  wire req    = reg_rd | reg_wr;
  wire mapped = (reg_addr >= `DIH_OFS_ID_LOWER) && (reg_addr <= `DIH_OFS_HEALTH);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Answer timing and decode
  a_ack_one_late: assert property (req |=> reg_ack) else $error("ack missing");
  a_ack_has_cause: assert property (reg_ack |-> $past(req)) else $error("stray ack");
  a_err_unmapped: assert property (req && !mapped |=> reg_err && reg_rdata == 16'h0000)
    else $error("unmapped not refused");
  a_err_mapped: assert property (req && mapped |=> !reg_err) else $error("mapped refused");
  a_rdata_idle: assert property (!reg_ack |-> reg_rdata == 16'h0000) else $error("rdata idle");
  // Fixed-zero bits of the identity registers
  a_upper_zero: assert property (reg_rd && reg_addr == `DIH_OFS_ID_UPPER |=>
    reg_rdata[15:8] == 8'h00) else $error("upper byte not zero");
  a_wafer_gaps: assert property (reg_rd && reg_addr == `DIH_OFS_WAFER_POS |=>
    !reg_rdata[15] && !reg_rdata[7]) else $error("wafer pad bits set");
  // Clock output and load state
  a_clk_low: assert property (!clk_out_en |=> !clock_output_pin) else $error("pin not low");
  a_clk_toggle: assert property (clk_out_en && $past(clk_out_en) && !$past(sys_rst) |=>
    clock_output_pin != $past(clock_output_pin)) else $error("pin not toggling");
  a_load_held: assert property (load_done |=> load_done) else $error("load lost");
endmodule : dih_regs_sva
bind dih_regs dih_regs_sva u_sva (.clk(clk), .sys_rst(sys_rst), .reg_rd(reg_rd),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .clk_out_en(clk_out_en), .reg_rdata(reg_rdata),
  .reg_ack(reg_ack), .reg_err(reg_err), .clock_output_pin(clock_output_pin),
  .load_done(load_done));

// ===== dih_host_model.sv
// Host model issuing register strobes in place of the serial engine.
// Assumes the one-cycle strobe and one-cycle-late answer of dih_regs.
`timescale 1ns/1ps
module dih_host_model (
  input  wire logic        clk,
  input  wire logic        reg_ack,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_err,
  output logic             reg_rd,
  output logic             reg_wr,
  output logic [15:0]      reg_addr,
  output logic [15:0]      reg_wdata
);
  initial begin
    reg_rd    = 1'b0;
    reg_wr    = 1'b0;
    reg_addr  = 16'h0000;
    reg_wdata = 16'h0000;
  end
  // Host view of a health word: errors in 5:3, warnings in 2:0
  function automatic logic [5:0] zone_view(input logic [15:0] h);
    return {h[14], h[12], h[10], h[15], h[13], h[11]};
  endfunction : zone_view
  // One transfer; on release the strobes drop low and address and write data are inverted so stale values never pass
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] wd,
                      output logic [15:0] d, output logic e, output logic got);
    @(posedge clk);
    #1;
    reg_rd    = !wr;
    reg_wr    = wr;
    reg_addr  = a;
    reg_wdata = wd;
    @(posedge clk);
    #1;
    reg_rd    = 1'b0;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~wd;
    got = reg_ack;
    d   = reg_rdata;
    e   = reg_err;
  endtask : xfer
endmodule : dih_host_model

// ===== dih_regs_test.sv
// Testbench of the identity and health registers, two factory images.
// Assumes dih_consts.svh and the host model; second instance shares the bus.
`timescale 1ns/1ps
`include "dih_consts.svh"
module dih_regs_test;
  // ****************
  // Images: A red single, yellow double+single; B green single, red double
  // ****************
  localparam logic [87:0] IMG_A = {22'h000004, 22'h230003, 22'h000003, 22'h2E0101};
  localparam logic [87:0] IMG_B = {22'h000003, 22'h230001, 22'h2E0101, 22'h000002};
  logic clk = 1'b0, sys_rst = 1'b1, clk_out_en = 1'b1;
  logic reg_rd, reg_wr, reg_ack, reg_err, pin, load_done, b_ack, b_err, b_pin, b_ld;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, b_rdata, d;
  logic        e, got;
  int          error_cnt = 0, n_checks = 0;
  always #10 clk = ~clk;
  dih_regs #(.NVM_IMAGE(IMG_A), .MFG_RESVD(10'h2A5)) u_dut (.clk(clk), .sys_rst(sys_rst),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .clk_out_en(clk_out_en), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err),
    .clock_output_pin(pin), .load_done(load_done));
  dih_regs #(.NVM_IMAGE(IMG_B), .MFG_RESVD(10'h000)) u_alt (.clk(clk), .sys_rst(sys_rst),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .clk_out_en(clk_out_en), .reg_rdata(b_rdata), .reg_ack(b_ack), .reg_err(b_err),
    .clock_output_pin(b_pin), .load_done(b_ld));
  dih_host_model u_host (.clk(clk), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
    .reg_err(reg_err), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // Early read gives health bits 15:10 zero, then load must finish in bounded time
  task automatic t_load;
    int n;
    u_host.xfer(1'b0, `DIH_OFS_HEALTH, 16'h0000, d, e, got);
    check("early health", d, 16'h02A5);
    check("early health b", b_rdata, 16'h0000);
    for (n = 0; n < 30 && load_done !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    check("load done", {15'h0, load_done & b_ld}, 16'h0001);
    $display("t_load done");
  endtask : t_load
  // Identity words and wafer position, both images
  task automatic t_ident;
    u_host.xfer(1'b0, `DIH_OFS_ID_UPPER, 16'h0000, d, e, got);
    check("upper a", d, 16'h0001);
    check("upper b", b_rdata, 16'h0001);
    u_host.xfer(1'b0, `DIH_OFS_WAFER_POS, 16'h0000, d, e, got);
    check("wafer a", d, 16'h0101);
    check("wafer b", b_rdata, 16'h0000);
    u_host.xfer(1'b0, `DIH_OFS_ID_LOWER, 16'h0000, d, e, got);
    check("lower a", d, 16'h0003);
    check("lower b", b_rdata, 16'h0101);
    $display("t_ident done");
  endtask : t_ident
  // Health read once, then writes to health and upper id, then read twice more
  task automatic t_health;
    int i;
    for (i = 0; i < 3; i++) begin
      if (i == 1) begin
        u_host.xfer(1'b1, `DIH_OFS_HEALTH, 16'hFFFF, d, e, got);
        check("wr ack", {14'h0, got, e}, 16'h0002);
        u_host.xfer(1'b1, `DIH_OFS_ID_UPPER, 16'hFFFF, d, e, got);
      end
      u_host.xfer(1'b0, `DIH_OFS_HEALTH, 16'h0000, d, e, got);
      check("health a", d, 16'hB2A5);
      check("health b", b_rdata, 16'h4800);
      check("zones a", {10'h000, u_host.zone_view(d)}, 16'h0016);
      check("zones b", {10'h000, u_host.zone_view(b_rdata)}, 16'h0021);
    end
    u_host.xfer(1'b0, `DIH_OFS_ID_UPPER, 16'h0000, d, e, got);
    check("upper kept", d, 16'h0001);
    $display("t_health done");
  endtask : t_health
  // Unmapped neighbours are refused with zero data
  task automatic t_unmapped;
    u_host.xfer(1'b0, 16'h1006, 16'h0000, d, e, got);
    check("unmapped hi", {d[14:0], e}, 16'h0001);
    check("unmapped b", {b_rdata[13:0], b_ack, b_err}, 16'h0003);
    u_host.xfer(1'b0, 16'h1001, 16'h0000, d, e, got);
    check("unmapped lo", {d[14:0], e}, 16'h0001);
    $display("t_unmapped done");
  endtask : t_unmapped
  // Pin toggles every cycle when on, stays low when off
  task automatic t_clock;
    int i, flips, lows;
    logic last;
    flips = 0;
    lows  = 0;
    @(posedge clk);
    #1;
    last = pin;
    for (i = 0; i < 10; i++) begin
      @(posedge clk);
      #1;
      if (pin !== last) flips++;
      last = pin;
    end
    check("flips", 16'(flips), 16'h000A);
    clk_out_en = 1'b0;
    @(posedge clk);
    for (i = 0; i < 5; i++) begin
      @(posedge clk);
      #1;
      if (pin === 1'b0 && b_pin === 1'b0) lows++;
    end
    check("lows", 16'(lows), 16'h0005);
    $display("t_clock done");
  endtask : t_clock
  initial begin
    repeat (4) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    t_load();
    // A load that never finished leaves nothing worth reading
    if (load_done === 1'b1) begin
      t_ident();
      t_health();
      t_unmapped();
      t_clock();
    end
    stop_test();
  end
endmodule : dih_regs_test
